// *** design/remappable_input_select.sv ***
`timescale 1ns/1ps
// Operation
// - external interrupt 1 follows the pin picked by bits 15:8 of its register.
// - external interrupt 2 follows the pin picked by bits 7:0 of its register.
// - each 8-bit field is a binary pin index, up to pin 181.
// - a field value of one routes pin 1.
// - a field of zero holds the input low.
// - bits 7:0 of the irq1 and timer1 registers ignore writes and read zero.
// - bits 15:8 of the irq2 register ignore writes and read zero.
// - any number of inputs may select the same pin at once.
module remappable_input_select #(
  parameter int unsigned PIN_COUNT = input_select_pkg::PIN_MAX
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [PIN_COUNT:1]   remappable_pin_n,
  output logic                      external_interrupt_1,
  output logic                      external_interrupt_2,
  output logic                      timer1_external_clock,
  output logic                      timer2_external_clock,
  output logic                      timer3_external_clock
);
  localparam int unsigned FW = input_select_pkg::FIELD_W;
  localparam int unsigned HI = input_select_pkg::HI_FIELD_LSB;
  localparam int unsigned LO = input_select_pkg::LO_FIELD_LSB;

  logic [FW-1:0] irq1_pin_select_r;
  logic [FW-1:0] irq2_pin_select_r;
  logic [FW-1:0] timer1_clock_pin_select_r;
  logic [FW-1:0] timer2_clock_pin_select_r;
  logic [FW-1:0] timer3_clock_pin_select_r;

  logic [3:0]    aw_addr_r;
  logic          aw_held_r;
  logic [31:0]   w_data_r;
  logic [3:0]    w_strb_r;
  logic          w_held_r;
  logic          do_write;

  function automatic logic known_addr(input logic [3:0] a);
    known_addr = a == input_select_pkg::IRQ1_SEL_OFF ||
                 a == input_select_pkg::IRQ2_SEL_OFF ||
                 a == input_select_pkg::TMR1_SEL_OFF ||
                 a == input_select_pkg::TMR23_SEL_OFF;
  endfunction

  // byte lane merge: keeps old bits where the strobe is low
  function automatic logic [FW-1:0] lane(input logic [FW-1:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s,
                                         input int unsigned lsb);
    lane = s[lsb/8] ? d[lsb +: 8] : old;
  endfunction

  // write channel: address and data taken in either order, held until both
  assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;

  // readies are flops that track !held && !bvalid, so no output is a gate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
    end else if ((s_axi_awvalid && s_axi_awready) || do_write) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
    end else if ((s_axi_wvalid && s_axi_wready) || do_write) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= input_select_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_addr(aw_addr_r) ? input_select_pkg::RESP_OKAY
                                            : input_select_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // unimplemented halves have no storage, so writes there vanish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq1_pin_select_r         <= input_select_pkg::SEL_RESET;
      irq2_pin_select_r         <= input_select_pkg::SEL_RESET;
      timer1_clock_pin_select_r <= input_select_pkg::SEL_RESET;
      timer2_clock_pin_select_r <= input_select_pkg::SEL_RESET;
      timer3_clock_pin_select_r <= input_select_pkg::SEL_RESET;
    end else if (do_write) begin
      case (aw_addr_r)
        input_select_pkg::IRQ1_SEL_OFF: begin
          irq1_pin_select_r <= lane(irq1_pin_select_r, w_data_r,
                                    w_strb_r, HI);
        end
        input_select_pkg::IRQ2_SEL_OFF: begin
          irq2_pin_select_r <= lane(irq2_pin_select_r, w_data_r,
                                    w_strb_r, LO);
        end
        input_select_pkg::TMR1_SEL_OFF: begin
          timer1_clock_pin_select_r <= lane(timer1_clock_pin_select_r,
                                            w_data_r, w_strb_r, HI);
        end
        input_select_pkg::TMR23_SEL_OFF: begin
          timer3_clock_pin_select_r <= lane(timer3_clock_pin_select_r,
                                            w_data_r, w_strb_r, HI);
          timer2_clock_pin_select_r <= lane(timer2_clock_pin_select_r,
                                            w_data_r, w_strb_r, LO);
        end
        default: begin
        end
      endcase
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= input_select_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= known_addr({s_axi_araddr[3:2], 2'b00})
                      ? input_select_pkg::RESP_OKAY
                      : input_select_pkg::RESP_SLVERR;
      case ({s_axi_araddr[3:2], 2'b00})
        input_select_pkg::IRQ1_SEL_OFF:
          s_axi_rdata <= {16'h0000, irq1_pin_select_r, 8'h00};
        input_select_pkg::IRQ2_SEL_OFF:
          s_axi_rdata <= {24'h00_0000, irq2_pin_select_r};
        input_select_pkg::TMR1_SEL_OFF:
          s_axi_rdata <= {16'h0000, timer1_clock_pin_select_r, 8'h00};
        input_select_pkg::TMR23_SEL_OFF:
          s_axi_rdata <= {16'h0000, timer3_clock_pin_select_r,
                          timer2_clock_pin_select_r};
        default:
          s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // five independent muxes, so any number may share one pin
  logic [5*FW-1:0] sels;
  logic [4:0]      routed;
  assign sels = {timer3_clock_pin_select_r, timer2_clock_pin_select_r,
                 timer1_clock_pin_select_r, irq2_pin_select_r,
                 irq1_pin_select_r};

  for (genvar g = 0; g < 5; g++) begin : g_mux
    pin_select_mux #(
      .PIN_COUNT (PIN_COUNT)
    ) u_mux (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pins    (remappable_pin_n),
      .sel     (sels[g*FW +: FW]),
      .pin_out (routed[g])
    );
  end

  assign external_interrupt_1  = routed[0];
  assign external_interrupt_2  = routed[1];
  assign timer1_external_clock = routed[2];
  assign timer2_external_clock = routed[3];
  assign timer3_external_clock = routed[4];

  a_irq1_route: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $stable(irq1_pin_select_r) && irq1_pin_select_r != 8'h00 &&
    irq1_pin_select_r <= 8'hb5 |=>
    external_interrupt_1 == $past(remappable_pin_n[irq1_pin_select_r]))
    else $error("irq1 not following selected pin");
  a_irq2_route: assert property (
    @(posedge aclk) disable iff (!aresetn)
    irq2_pin_select_r == 8'h01 |=>
    external_interrupt_2 == $past(remappable_pin_n[1]))
    else $error("irq2 not following pin 1");
  a_ground_sel: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timer1_clock_pin_select_r == 8'h00 |=> !timer1_external_clock)
    else $error("grounded timer1 clock not low");
  a_top_code: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timer2_clock_pin_select_r == 8'hb5 |=>
    timer2_external_clock == $past(remappable_pin_n[181]))
    else $error("code b5 not routing pin 181");
  a_irq1_low_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(s_axi_araddr[3:2]) == 2'd0 && $rose(s_axi_rvalid)
    |-> s_axi_rdata[7:0] == 8'h00)
    else $error("irq1 low byte not zero");
  a_irq2_high_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && $past(s_axi_araddr[3:2]) == 2'd1
    |-> s_axi_rdata[15:8] == 8'h00)
    else $error("irq2 high byte not zero");
  a_t3_route: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timer3_clock_pin_select_r == 8'hb4 ##1
    timer3_clock_pin_select_r == 8'hb4 |->
    timer3_external_clock == $past(remappable_pin_n[180]))
    else $error("timer3 not following pin 180");
  a_shared_pin: assert property (
    @(posedge aclk) disable iff (!aresetn)
    irq1_pin_select_r == irq2_pin_select_r |=>
    external_interrupt_1 == external_interrupt_2)
    else $error("shared pin gives differing inputs");
endmodule

// *** design/input_select_pkg.sv ***
package input_select_pkg;
  localparam int unsigned        DATA_W        = 32;
  localparam int unsigned        ADDR_W        = 4;
  localparam int unsigned        FIELD_W       = 8;
  localparam int unsigned        REG_COUNT     = 4;
  localparam int unsigned        PIN_MAX       = 181;
  // register byte offsets
  localparam logic [ADDR_W-1:0]  IRQ1_SEL_OFF  = 4'h0;
  localparam logic [ADDR_W-1:0]  IRQ2_SEL_OFF  = 4'h4;
  localparam logic [ADDR_W-1:0]  TMR1_SEL_OFF  = 4'h8;
  localparam logic [ADDR_W-1:0]  TMR23_SEL_OFF = 4'hc;
  // field positions (low bit of each byte field)
  localparam int unsigned        HI_FIELD_LSB  = 8;
  localparam int unsigned        LO_FIELD_LSB  = 0;
  localparam logic [FIELD_W-1:0] SEL_RESET     = 8'h00;
  localparam logic [FIELD_W-1:0] SEL_GROUND    = 8'h00;
  localparam logic [1:0]         RESP_OKAY     = 2'b00;
  localparam logic [1:0]         RESP_SLVERR   = 2'b10;
endpackage

// *** design/pin_select_mux.sv ***
`timescale 1ns/1ps
// one remapped input: index 0 is ground, n picks pin n, out of range reads low
module pin_select_mux #(
  parameter int unsigned PIN_COUNT = 181
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [PIN_COUNT:1]   pins,
  input  wire logic [7:0]           sel,
  output logic                      pin_out
);
  logic [PIN_COUNT:0] padded;
  logic               pin_nxt;

  assign padded = {pins, 1'b0};

  always_comb begin
    if (sel == 8'h00 || 32'(sel) > PIN_COUNT) begin
      pin_nxt = 1'b0;
    end else begin
      pin_nxt = padded[sel];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= pin_nxt;
    end
  end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("[ERR] t=%0t got %h exp %h", $time, got, exp); \
  end end
module tb;
  logic         aclk, aresetn;
  logic [3:0]   s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready;
  logic [181:1] pins;
  logic         irq1, irq2, tck1, tck2, tck3;
  int           miscompares, total_checks, cycles;

  remappable_input_select dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .remappable_pin_n(pins), .external_interrupt_1(irq1),
    .external_interrupt_2(irq2), .timer1_external_clock(tck1),
    .timer2_external_clock(tck2), .timer3_external_clock(tck3));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  function automatic logic [181:1] one_hot(int n);
    logic [181:1] v;
    v = '0;
    v[n] = 1'b1;
    return v;
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic wr(logic [3:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, input_select_pkg::RESP_OKAY)
  endtask

  task automatic rd_chk(logic [3:0] a, logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    `CHK(rd, exp)
    `CHK(rsp, input_select_pkg::RESP_OKAY)
  endtask

  // pins are sampled and the routed outputs registered, so allow slack
  task automatic put_pins(logic [181:1] v);
    @(posedge aclk);
    pins <= v;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task automatic test_reset();
    for (int i = 0; i < 4; i++) rd_chk(4'(i * 4), 32'h0000_0000);
    put_pins('1);
    `CHK({irq1, irq2, tck1, tck2, tck3}, 5'h00)
    $display("test_reset done");
  endtask

  task automatic test_irq1();
    wr(4'h0, 32'hffff_ffff, 4'hf);
    rd_chk(4'h0, 32'h0000_ff00);
    wr(4'h0, 32'h0000_b5a5, 4'hf);
    rd_chk(4'h0, 32'h0000_b500);
    put_pins(one_hot(181));
    `CHK(irq1, 1'b1)
    put_pins(~one_hot(181));
    `CHK(irq1, 1'b0)
    $display("test_irq1 done");
  endtask

  task automatic test_irq2();
    wr(4'h4, 32'hffff_ffff, 4'hf);
    rd_chk(4'h4, 32'h0000_00ff);
    wr(4'h4, 32'h0000_c3b4, 4'hf);
    rd_chk(4'h4, 32'h0000_00b4);
    put_pins(one_hot(180));
    `CHK(irq2, 1'b1)
    put_pins(~one_hot(180));
    `CHK(irq2, 1'b0)
    $display("test_irq2 done");
  endtask

  task automatic test_timers();
    wr(4'h8, 32'h0000_01ff, 4'hf);
    rd_chk(4'h8, 32'h0000_0100);
    wr(4'hc, 32'h0000_0505, 4'hf);
    rd_chk(4'hc, 32'h0000_0505);
    wr(4'h0, 32'h0000_0500, 4'hf);
    put_pins(one_hot(5));
    `CHK({irq1, tck1, tck2, tck3}, 4'b1011)
    put_pins(one_hot(1));
    `CHK({irq1, tck1, tck2, tck3}, 4'b0100)
    // lane 0 only: timer 3 keeps its pin, timer 2 moves to pin 1
    wr(4'hc, 32'h0000_0901, 4'h1);
    rd_chk(4'hc, 32'h0000_0501);
    `CHK({tck2, tck3}, 2'b10)
    // the two top codes: timer 3 on pin 180, timer 2 on pin 181
    wr(4'hc, 32'h0000_b4b5, 4'hf);
    put_pins(one_hot(180));
    `CHK({tck2, tck3}, 2'b01)
    put_pins(one_hot(181));
    `CHK({tck2, tck3}, 2'b10)
    $display("test_timers done");
  endtask

  task automatic test_ground();
    for (int i = 0; i < 4; i++) wr(4'(i * 4), 32'h0000_0000, 4'hf);
    put_pins('1);
    `CHK({irq1, irq2, tck1, tck2, tck3}, 5'h00)
    $display("test_ground done");
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    pins = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_irq1();
    test_irq2();
    test_timers();
    test_ground();
    end_of_test();
  end
endmodule
